// file: pkg/rnw_map.svh
`ifndef RNW_MAP_SVH
`define RNW_MAP_SVH

// Host register space regions
`define RNW_CTL_BASE   32'h0000a000
`define RNW_EE_BASE    32'hff7fe000
`define RNW_FL_BASE    32'hff800000
`define RNW_WADDR_REG  32'hff810000

// Region decode fields
`define RNW_FL_TAG     9'h1ff
`define RNW_EE_TAG     19'h7fbff
`define RNW_BUF_TAG    16'hff80

// Window and staging block geometry
`define RNW_FL_AW      23
`define RNW_EE_AW      13
`define RNW_BUF_AW     14
`define RNW_BUF_LAST   14'h3fff

`endif

// file: pkg/rnw_pkg.sv
package rnw_pkg;

    typedef enum logic [1:0] {
        RNW_OP_READ,
        RNW_OP_WRITE,
        RNW_OP_ERASE
    } rnw_op_type;

    // Host register access
    typedef struct packed {
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } rnw_req_type;

    // Forwarded bootstrap / control register access
    typedef struct packed {
        logic        ctl;
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } rnw_loc_type;

    // Flash command: read four bytes, erase block, program four bytes
    typedef struct packed {
        rnw_op_type  op;
        logic [22:0] addr;
        logic [31:0] wdata;
    } rnw_fl_type;

    typedef struct packed {
        logic        write;
        logic [12:0] addr;
        logic [31:0] wdata;
    } rnw_ee_type;

endpackage

// file: src/rnw_stage_mem.sv
`timescale 1ns/1ns
`include "rnw_map.svh"

module rnw_stage_mem (
    input  wire logic                    i_clk,   // System clock
    input  wire logic                    i_we,    // Write strobe
    input  wire logic [`RNW_BUF_AW-1:0]  i_waddr, // Word write address
    input  wire logic [31:0]             i_wdata, // Write data
    input  wire logic [`RNW_BUF_AW-1:0]  i_raddr, // Word read address
    output logic      [31:0]             o_rdata  // Registered read data
);

    logic [31:0] mem [0:(1<<`RNW_BUF_AW)-1];

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        o_rdata <= mem[i_raddr];
    end

endmodule

// file: src/rnw_window.sv
`timescale 1ns/1ns
`include "rnw_map.svh"
// Notes on behaviour
// - Space splits into bootstrap, control, EEPROM and flash regions.
// - From the vendor base upward: control, EEPROM window, flash window.
// - Top 8 MB of register space maps onto boot flash.
// - Flash read address is register address minus window base; four bytes.
// - No direct flash writes; staged through buffer and address register.
// - Flash writes use whole 64 kB blocks from the staging buffer.
// - Write-address write erases the 64 kB block, then programs it.
// - EEPROM window decodes the 8 kB just below the flash window.
// - EEPROM address is register address minus base; four bytes moved.

module rnw_window (
    input  wire logic                 i_clk,       // 100 MHz clock
    input  wire logic                 i_rst_b,     // Sync reset, active low
    input  wire logic                 i_req_valid, // Host access request
    input  wire rnw_pkg::rnw_req_type i_req,       // Host access
    output logic                      o_req_ready, // Request may be taken
    output logic                      o_rsp_valid, // Answer pulse
    output logic      [31:0]          o_rsp_rdata, // Read data
    output logic                      o_busy,      // Block program running
    output logic                      o_loc_valid, // Local access pulse
    output rnw_pkg::rnw_loc_type      o_loc_req,   // Local access
    input  wire logic                 i_loc_done,  // Local access done
    input  wire logic [31:0]          i_loc_rdata, // Local read data
    output logic                      o_fl_valid,  // Flash command pulse
    output rnw_pkg::rnw_fl_type       o_fl_cmd,    // Flash command
    input  wire logic                 i_fl_done,   // Flash command done
    input  wire logic [31:0]          i_fl_rdata,  // Flash read data
    output logic                      o_ee_valid,  // EEPROM command pulse
    output rnw_pkg::rnw_ee_type       o_ee_cmd,    // EEPROM command
    input  wire logic                 i_ee_done,   // EEPROM command done
    input  wire logic [31:0]          i_ee_rdata   // EEPROM read data
);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LOC,
        ST_FL_RD,
        ST_EE,
        ST_ERASE,
        ST_PRG_RD,
        ST_PRG_ISSUE,
        ST_PRG_WAIT
    } rnw_state_type;

    rnw_state_type               state_r;
    logic [`RNW_BUF_AW-1:0]      idx_r;
    logic [6:0]                  blk_r;
    logic [31:0]                 buf_rdata;
    logic                        take;
    logic                        in_fl;
    logic                        in_buf;
    logic                        in_wa;
    logic                        in_ee;
    logic                        in_ctl;
    logic                        buf_we;

    // Region decode of the incoming address
    assign take   = i_req_valid && o_req_ready;
    assign in_fl  = i_req.addr[31:23] == `RNW_FL_TAG;
    assign in_buf = i_req.addr[31:16] == `RNW_BUF_TAG;
    assign in_wa  = i_req.addr == `RNW_WADDR_REG;
    assign in_ee  = i_req.addr[31:13] == `RNW_EE_TAG;
    assign in_ctl = !in_fl && !in_ee && (i_req.addr >= `RNW_CTL_BASE);

    assign buf_we = take && i_req.write && in_buf;

    rnw_stage_mem u_stage_mem (
        .i_clk   (i_clk),
        .i_we    (buf_we),
        .i_waddr (i_req.addr[`RNW_BUF_AW+1:2]),
        .i_wdata (i_req.wdata),
        .i_raddr (idx_r),
        .o_rdata (buf_rdata)
    );

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            state_r     <= ST_IDLE;
            o_req_ready <= 1'b1;
            o_rsp_valid <= 1'b0;
            o_rsp_rdata <= 32'h00000000;
            o_busy      <= 1'b0;
            o_loc_valid <= 1'b0;
            o_loc_req   <= '0;
            o_fl_valid  <= 1'b0;
            o_fl_cmd    <= '0;
            o_ee_valid  <= 1'b0;
            o_ee_cmd    <= '0;
            idx_r       <= '0;
            blk_r       <= 7'h00;
        end else begin
            o_rsp_valid <= 1'b0;
            o_loc_valid <= 1'b0;
            o_fl_valid  <= 1'b0;
            o_ee_valid  <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (take) begin
                        o_req_ready <= 1'b0;
                        o_rsp_rdata <= 32'h00000000;
                        if (in_fl && !i_req.write) begin
                            o_fl_valid    <= 1'b1;
                            o_fl_cmd.op   <= rnw_pkg::RNW_OP_READ;
                            o_fl_cmd.addr <= 23'(i_req.addr - `RNW_FL_BASE);
                            state_r       <= ST_FL_RD;
                        end else if (in_wa) begin
                            blk_r         <= i_req.wdata[22:16];
                            idx_r         <= '0;
                            o_busy        <= 1'b1;
                            o_rsp_valid   <= 1'b1;
                            o_fl_valid    <= 1'b1;
                            o_fl_cmd.op   <= rnw_pkg::RNW_OP_ERASE;
                            o_fl_cmd.addr <= {i_req.wdata[22:16], 16'h0000};
                            state_r       <= ST_ERASE;
                        end else if (in_fl) begin
                            // staged or dropped, answered at once
                            o_rsp_valid <= 1'b1;
                            o_req_ready <= 1'b1;
                        end else if (in_ee) begin
                            o_ee_valid     <= 1'b1;
                            o_ee_cmd.write <= i_req.write;
                            o_ee_cmd.addr  <= 13'(i_req.addr - `RNW_EE_BASE);
                            o_ee_cmd.wdata <= i_req.wdata;
                            state_r        <= ST_EE;
                        end else begin
                            o_loc_valid     <= 1'b1;
                            o_loc_req.ctl   <= in_ctl;
                            o_loc_req.write <= i_req.write;
                            o_loc_req.addr  <= i_req.addr;
                            o_loc_req.wdata <= i_req.wdata;
                            state_r         <= ST_LOC;
                        end
                    end
                end
                ST_LOC: begin
                    if (i_loc_done) begin
                        o_rsp_valid <= 1'b1;
                        o_rsp_rdata <= o_loc_req.write ? 32'h00000000
                                                       : i_loc_rdata;
                        o_req_ready <= 1'b1;
                        state_r     <= ST_IDLE;
                    end
                end
                ST_FL_RD: begin
                    if (i_fl_done) begin
                        o_rsp_valid <= 1'b1;
                        o_rsp_rdata <= i_fl_rdata;
                        o_req_ready <= 1'b1;
                        state_r     <= ST_IDLE;
                    end
                end
                ST_EE: begin
                    if (i_ee_done) begin
                        o_rsp_valid <= 1'b1;
                        o_rsp_rdata <= o_ee_cmd.write ? 32'h00000000
                                                      : i_ee_rdata;
                        o_req_ready <= 1'b1;
                        state_r     <= ST_IDLE;
                    end
                end
                ST_ERASE: begin
                    if (i_fl_done) begin
                        state_r <= ST_PRG_RD;
                    end
                end
                ST_PRG_RD: begin
                    // Staging memory has one cycle of read latency
                    state_r <= ST_PRG_ISSUE;
                end
                ST_PRG_ISSUE: begin
                    o_fl_valid     <= 1'b1;
                    o_fl_cmd.op    <= rnw_pkg::RNW_OP_WRITE;
                    o_fl_cmd.addr  <= {blk_r, idx_r, 2'b00};
                    o_fl_cmd.wdata <= buf_rdata;
                    state_r        <= ST_PRG_WAIT;
                end
                ST_PRG_WAIT: begin
                    if (i_fl_done) begin
                        idx_r <= idx_r + 1'b1;
                        if (idx_r == `RNW_BUF_LAST) begin
                            o_busy      <= 1'b0;
                            o_req_ready <= 1'b1;
                            state_r     <= ST_IDLE;
                        end else begin
                            state_r <= ST_PRG_RD;
                        end
                    end
                end
                default: begin
                    state_r     <= ST_IDLE;
                    o_req_ready <= 1'b1;
                end
            endcase
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    property p_boot_region;
        take && (i_req.addr < `RNW_CTL_BASE)
            |=> o_loc_valid && !o_loc_req.ctl;
    endproperty
    a_boot_region: assert property (p_boot_region)
        else $error("bootstrap access not forwarded");

    property p_ctl_region;
        take && in_ctl |=> o_loc_valid && o_loc_req.ctl;
    endproperty
    a_ctl_region: assert property (p_ctl_region)
        else $error("control access not forwarded");

    property p_fl_exclusive;
        take && in_fl |=> !o_ee_valid && !o_loc_valid;
    endproperty
    a_fl_exclusive: assert property (p_fl_exclusive)
        else $error("flash window access leaked");

    property p_fl_read;
        take && in_fl && !i_req.write |=> o_fl_valid
            && o_fl_cmd.op == rnw_pkg::RNW_OP_READ
            && o_fl_cmd.addr == 23'($past(i_req.addr) - `RNW_FL_BASE);
    endproperty
    a_fl_read: assert property (p_fl_read)
        else $error("flash read address wrong");

    property p_fl_wait;
        state_r == ST_FL_RD && !i_fl_done |=> !o_rsp_valid;
    endproperty
    a_fl_wait: assert property (p_fl_wait)
        else $error("flash read answered before data");

    property p_no_direct;
        take && i_req.write && in_fl && !in_wa |=> !o_fl_valid
            && o_rsp_valid && o_req_ready;
    endproperty
    a_no_direct: assert property (p_no_direct)
        else $error("direct flash write issued");

    property p_prog_addr;
        o_fl_valid && o_fl_cmd.op == rnw_pkg::RNW_OP_WRITE
            |-> o_fl_cmd.addr[15:2] == idx_r && o_busy;
    endproperty
    a_prog_addr: assert property (p_prog_addr)
        else $error("program word outside block walk");

    property p_erase;
        take && in_wa |=> o_fl_valid && o_busy
            && o_fl_cmd.op == rnw_pkg::RNW_OP_ERASE
            && o_fl_cmd.addr[15:0] == 16'h0000;
    endproperty
    a_erase: assert property (p_erase)
        else $error("erase not started");

    property p_ee_decode;
        take && i_req.addr >= `RNW_EE_BASE && i_req.addr < `RNW_FL_BASE
            |=> o_ee_valid;
    endproperty
    a_ee_decode: assert property (p_ee_decode)
        else $error("EEPROM window not decoded");

    property p_ee_addr;
        take && in_ee |=> o_ee_cmd.write == $past(i_req.write)
            && o_ee_cmd.addr == 13'($past(i_req.addr) - `RNW_EE_BASE);
    endproperty
    a_ee_addr: assert property (p_ee_addr)
        else $error("EEPROM address wrong");

    property p_protect;
        take && i_req.write && in_fl && !in_buf |-> !buf_we;
    endproperty
    a_protect: assert property (p_protect)
        else $error("protected area written");

    c_fl_read:  cover property (take && in_fl && !i_req.write);
    c_ee_write: cover property (take && in_ee && i_req.write);
    c_prog_end: cover property (state_r == ST_PRG_WAIT && i_fl_done
                                && idx_r == `RNW_BUF_LAST);

endmodule

// file: tb/rnw_far_port.sv
`timescale 1ns/1ns

// Flash, EEPROM or local register backend; one instance for each
module rnw_far_port (
    input  wire logic        i_clk,   // System clock
    input  wire logic        i_slow,  // Late answers
    input  wire logic        i_valid, // Command pulse
    input  wire logic        i_write, // Store four bytes
    input  wire logic        i_erase, // Clear 64 kB block
    input  wire logic [31:0] i_addr,  // Byte address
    input  wire logic [31:0] i_wdata, // Store data
    output logic             o_done,  // Done pulse
    output logic      [31:0] o_rdata  // Read data
);
    logic [7:0]  mem [int];
    logic [31:0] a;
    logic [31:0] d;
    logic        w;
    logic        e;

    // Unwritten bytes follow the address, so misrouting shows
    function automatic logic [7:0] rb(input logic [31:0] x);
        return mem.exists(x) ? mem[x] : x[7:0] ^ x[22:15];
    endfunction

    initial begin
        o_done  = 1'b0;
        o_rdata = 32'h0;
        forever begin
            @(posedge i_clk);
            if (i_valid) begin
                a = i_addr;
                d = i_wdata;
                w = i_write;
                e = i_erase;
                repeat (i_slow ? 3 : 0) @(posedge i_clk);
                if (e)
                    for (int i = 0; i < 65536; i++) mem[a + i] = 8'hff;
                else if (w)
                    for (int i = 0; i < 4; i++) mem[a + i] = d[8 * i +: 8];
                o_rdata <= {rb(a + 3), rb(a + 2), rb(a + 1), rb(a)};
                o_done  <= 1'b1;
                @(posedge i_clk);
                o_done  <= 1'b0;
                // Stale data must not pass for valid
                o_rdata <= ~o_rdata;
            end
        end
    end
endmodule

// file: tb/tb.sv
`timescale 1ns/1ns

module tb;
    // Load 16k words, then about 4 cycles per programmed word
    localparam int LIMIT = 95000;
    logic                 i_clk, i_rst_b, i_req_valid, slow;
    rnw_pkg::rnw_req_type i_req;
    logic                 o_req_ready, o_rsp_valid, o_busy;
    logic                 o_loc_valid, o_fl_valid, o_ee_valid;
    logic                 loc_done, fl_done, ee_done, wr;
    rnw_pkg::rnw_loc_type o_loc_req;
    rnw_pkg::rnw_fl_type  o_fl_cmd;
    rnw_pkg::rnw_ee_type  o_ee_cmd;
    logic [31:0]          o_rsp_rdata, loc_rdata, fl_rdata, ee_rdata;
    logic [31:0]          cur_ad, r, ad;
    logic [7:0]           m [longint];
    logic [31:0]          bw [16384];
    logic [6:0]           blk;
    int                   seed = 2964;
    int                   errors = 0;
    int                   cmp_count = 0;
    int                   cycles = 0;
    int                   k;
    logic [31:0] edge_ad [7] = '{32'h00009ffc, 32'h0000a000, 32'hff7fdffc,
        32'hff7fe000, 32'hff7ffffc, 32'hff800000, 32'hfffffffc};
    logic [31:0] base [5] = '{32'h0, 32'ha000, 32'hff7fe000, 32'hff810004,
        32'hff800000};
    logic [31:0] span [5] = '{32'ha000, 32'hff7f4000, 32'h2000, 32'h7efffc,
        32'h800000};
    logic [31:0] offs [6] = '{32'hfffffffc, 32'h0, 32'hfe, 32'hfc, 32'h100,
        32'hfffc};

    rnw_window dut (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_req_valid(i_req_valid),
        .i_req(i_req), .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid),
        .o_rsp_rdata(o_rsp_rdata), .o_busy(o_busy),
        .o_loc_valid(o_loc_valid), .o_loc_req(o_loc_req),
        .i_loc_done(loc_done), .i_loc_rdata(loc_rdata),
        .o_fl_valid(o_fl_valid), .o_fl_cmd(o_fl_cmd), .i_fl_done(fl_done),
        .i_fl_rdata(fl_rdata), .o_ee_valid(o_ee_valid), .o_ee_cmd(o_ee_cmd),
        .i_ee_done(ee_done), .i_ee_rdata(ee_rdata));
    rnw_far_port loc_far (
        .i_clk(i_clk), .i_slow(slow), .i_valid(o_loc_valid),
        .i_write(o_loc_req.write), .i_erase(1'b0), .i_addr(o_loc_req.addr),
        .i_wdata(o_loc_req.wdata), .o_done(loc_done), .o_rdata(loc_rdata));
    rnw_far_port ee_far (
        .i_clk(i_clk), .i_slow(slow), .i_valid(o_ee_valid),
        .i_write(o_ee_cmd.write), .i_erase(1'b0),
        .i_addr({19'h0, o_ee_cmd.addr}), .i_wdata(o_ee_cmd.wdata),
        .o_done(ee_done), .o_rdata(ee_rdata));
    rnw_far_port fl_far (
        .i_clk(i_clk), .i_slow(slow), .i_valid(o_fl_valid),
        .i_write(o_fl_cmd.op == rnw_pkg::RNW_OP_WRITE),
        .i_erase(o_fl_cmd.op == rnw_pkg::RNW_OP_ERASE),
        .i_addr({9'h0, o_fl_cmd.addr}), .i_wdata(o_fl_cmd.wdata),
        .o_done(fl_done), .o_rdata(fl_rdata));

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    task automatic print_verdict();
        $display("Compares %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk_word(input string nm, input logic [31:0] ex,
                            input logic [31:0] got);
        cmp_count++;
        if (got !== ex) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic chk_bit(input string nm, input logic ex, input logic got);
        cmp_count++;
        if (got !== ex) begin
            errors++;
            $display("MISMATCH %s expected %b seen %b", nm, ex, got);
        end
    endtask

    function automatic logic [7:0] mb(input int rg, input logic [31:0] a);
        return m.exists({rg[1:0], a}) ? m[{rg[1:0], a}] : a[7:0] ^ a[22:15];
    endfunction

    // One host access from a falling edge; returns at the answer
    task automatic host(input logic hw, input logic [31:0] ha,
                        input logic [31:0] wd);
        int          rg;
        logic [31:0] a;
        logic [31:0] ex;
        logic [31:0] sr;
        rg = 0;
        a = ha;
        if (ha >= 32'hff800000) begin
            rg = 2;
            a = ha - 32'hff800000;
        end else if (ha >= 32'hff7fe000) begin
            rg = 1;
            a = ha - 32'hff7fe000;
        end
        ex = hw ? 32'h0 : {mb(rg, a + 3), mb(rg, a + 2), mb(rg, a + 1),
                           mb(rg, a)};
        if (hw && rg < 2)
            for (int i = 0; i < 4; i++) m[{rg[1:0], a + i}] = wd[8 * i +: 8];
        sr = $random(seed);
        // Program walk runs fast to stay inside the cycle budget
        slow = sr[0] && !o_busy;
        cur_ad = ha;
        i_req_valid = 1'b1;
        i_req = '{write: hw, addr: ha, wdata: wd};
        @(posedge i_clk);
        while (o_req_ready !== 1'b1) @(posedge i_clk);
        @(negedge i_clk);
        // Fast answers leave valid up for the next call's request
        if (o_rsp_valid !== 1'b1)
            i_req_valid = 1'b0;
        while (o_rsp_valid !== 1'b1) @(negedge i_clk);
        chk_word("rdata", ex, o_rsp_rdata);
    endtask

    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            errors++;
            print_verdict();
        end
    end

    always @(posedge i_clk) begin
        if (o_loc_valid === 1'b1) begin
            chk_bit("loc_ctl", cur_ad >= 32'ha000, o_loc_req.ctl);
            chk_word("loc_addr", cur_ad, o_loc_req.addr);
        end
        if (o_ee_valid === 1'b1)
            chk_word("ee_addr", cur_ad - 32'hff7fe000,
                     {19'h0, o_ee_cmd.addr});
        if (o_fl_valid === 1'b1 && o_fl_cmd.op === rnw_pkg::RNW_OP_ERASE)
            chk_word("erase", {9'h0, blk, 16'h0},
                     {9'h0, o_fl_cmd.addr});
        if (o_busy === 1'b1)
            chk_bit("ready", 1'b0, o_req_ready);
    end

    initial begin
        i_rst_b = 1'b0;
        i_req_valid = 1'b0;
        i_req = '0;
        slow = 1'b0;
        blk = 7'h0;
        cur_ad = 32'h0;
        repeat (3) @(negedge i_clk);
        i_rst_b = 1'b1;
        chk_bit("ready", 1'b1, o_req_ready);
        chk_bit("busy", 1'b0, o_busy);
        foreach (edge_ad[j]) host(1'b0, edge_ad[j], 32'h0);
        for (int i = 0; i < 50; i++) begin
            r = $random(seed);
            k = i % 5;
            ad = base[k] + r % span[k];
            wr = r[31] && k < 4;
            host(wr, ad, $random(seed));
            if (wr) host(1'b0, ad, 32'h0);
        end
        for (int i = 0; i < 16384; i++) begin
            r = $random(seed);
            bw[i] = (i < 64) ? r : 32'hffffffff;
            host(1'b1, 32'hff800000 + 4 * i, bw[i]);
        end
        host(1'b0, 32'hff800000, 32'h0);
        r = $random(seed);
        blk = r[6:0] | 7'h01;
        // trigger only after the full load
        host(1'b1, 32'hff810000, {9'h0, blk, r[15:0]});
        chk_bit("busy", 1'b1, o_busy);
        for (int i = 0; i < 16384; i++)
            for (int j = 0; j < 4; j++)
                m[{2'b10, 9'h0, blk, i[13:0], j[1:0]}] = bw[i][8 * j +: 8];
        foreach (offs[j]) begin
            ad = 32'hff800000 + {9'h0, blk, 16'h0} + offs[j];
            host(1'b0, ad, 32'h0);
        end
        print_verdict();
    end
endmodule
